// >>> tpoc_map.svh
// constants of the three-phase overcurrent trip block
`ifndef TPOC_MAP_SVH
`define TPOC_MAP_SVH

// clock and evaluation tick
`define TPOC_CLK_PERIOD_NS 5
`define TPOC_TICK_MS       1
`define TPOC_TICK_CYCLES   ((`TPOC_TICK_MS * 1000000) / `TPOC_CLK_PERIOD_NS)

// setting defaults (percent, milliseconds)
`define TPOC_DEF_START_PCT 12'd200
`define TPOC_DEF_MIN_MS    16'd100
`define TPOC_DEF_DT_MS     16'd100

// operate-curve ratio breakpoints in tenths of the start threshold
`define TPOC_BP1 32'd11
`define TPOC_BP2 32'd15
`define TPOC_BP3 32'd20
`define TPOC_BP4 32'd30
`define TPOC_BP5 32'd50
`define TPOC_BP6 32'd70
`define TPOC_BP7 32'd100
`define TPOC_BP8 32'd200

// reset-curve ratio breakpoints in percent, factors 1/(1-r^2) scaled by 256
`define TPOC_RBP1 32'd50
`define TPOC_RBP2 32'd80
`define TPOC_RBP3 32'd90
`define TPOC_RFAC0 32'd256
`define TPOC_RFAC1 32'd341
`define TPOC_RFAC2 32'd711
`define TPOC_RFAC3 32'd1347
`define TPOC_RFAC_SHIFT 8
`define TPOC_TMS_SCALE 32'd100

`endif

// >>> tpoc_pkg.sv
// types of the three-phase overcurrent trip block
`default_nettype none
package tpoc_pkg;

	typedef enum logic [3:0] {
		TPOC_OFF            = 4'h0,
		TPOC_DEFINITE       = 4'h1,
		TPOC_IEC_INV        = 4'h2,
		TPOC_IEC_VERY_INV   = 4'h3,
		TPOC_IEC_EXT_INV    = 4'h4,
		TPOC_IEC_LONG_INV   = 4'h5,
		TPOC_ANSI_INV       = 4'h6,
		TPOC_ANSI_MOD_INV   = 4'h7,
		TPOC_ANSI_VERY_INV  = 4'h8,
		TPOC_ANSI_EXT_INV   = 4'h9,
		TPOC_ANSI_LONG_INV  = 4'ha,
		TPOC_ANSI_LVERY_INV = 4'hb,
		TPOC_ANSI_LEXT_INV  = 4'hc
	} tpoc_curve_e;

	typedef enum logic [1:0] {
		TPOC_IDLE      = 2'h0,
		TPOC_RUN       = 2'h1,
		TPOC_TRIPPED   = 2'h2,
		TPOC_RESETTING = 2'h3
	} tpoc_state_e;

	typedef struct packed {
		tpoc_curve_e curve;          // characteristic selection
		logic [11:0] start_threshold; // percent of nominal, 10..3000
		logic [10:0] time_mult;      // hundredths, 5..1500
		logic [15:0] min_delay_ms;   // 40..60000
		logic [15:0] def_delay_ms;   // 40..60000
		logic [15:0] reset_delay_ms; // 60..60000
	} tpoc_setting_s;

	typedef struct packed {
		logic start;
		logic trip;
	} tpoc_flags_s;

endpackage
`default_nettype wire

// >>> tpoc_phase.sv
// per-phase operate and reset timer of the overcurrent trip block
`default_nettype none
module tpoc_phase
	import tpoc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic        ms_tick,
	input  wire logic        clear,
	input  wire logic        above,
	input  wire logic        immed_reset,
	input  wire logic [31:0] op_delay,
	input  wire logic [31:0] rst_delay,
	output tpoc_flags_s      flags
);

	tpoc_state_e state_q, state_d;
	logic [31:0] elapsed_q, elapsed_d;
	logic [31:0] rcnt_q, rcnt_d;
	logic [31:0] elapsed_nx;
	tpoc_flags_s flags_q, flags_d;

	// ********************************************
	// timer state machine
	// ********************************************
	// the operate delay is re-read every cycle, so a rising current shortens a running delay
	always_comb begin
		state_d    = state_q;
		elapsed_d  = elapsed_q;
		rcnt_d     = rcnt_q;
		elapsed_nx = ms_tick ? elapsed_q + 32'd1 : elapsed_q;
		if (clear) begin
			state_d   = TPOC_IDLE;
			elapsed_d = 32'd0;
			rcnt_d    = 32'd0;
		end else begin
			case (state_q)
				TPOC_IDLE: begin
					if (above) begin
						state_d   = TPOC_RUN;
						elapsed_d = 32'd0;
					end
				end
				TPOC_RUN, TPOC_TRIPPED: begin
					if (!above) begin
						rcnt_d  = 32'd0;
						state_d = immed_reset ? TPOC_IDLE : TPOC_RESETTING;
					end else begin
						elapsed_d = elapsed_nx;
						if (elapsed_nx >= op_delay) begin
							state_d = TPOC_TRIPPED;
						end
					end
				end
				TPOC_RESETTING: begin
					// elapsed time is kept so a returning fault trips sooner
					if (above) begin
						state_d = TPOC_RUN;
					end else if (ms_tick) begin
						rcnt_d = rcnt_q + 32'd1;
						if (rcnt_q + 32'd1 >= rst_delay) begin
							state_d   = TPOC_IDLE;
							elapsed_d = 32'd0;
						end
					end
				end
				default: begin
					state_d = TPOC_IDLE;
				end
			endcase
		end
		flags_d.start = (state_d == TPOC_RUN) || (state_d == TPOC_TRIPPED);
		flags_d.trip  = (state_d == TPOC_TRIPPED);
	end

	// registers, frozen while clk_en is low
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_q   <= TPOC_IDLE;
			elapsed_q <= 32'd0;
			rcnt_q    <= 32'd0;
			flags_q   <= '0;
		end else if (clk_en) begin
			state_q   <= state_d;
			elapsed_q <= elapsed_d;
			rcnt_q    <= rcnt_d;
			flags_q   <= flags_d;
		end
	end

	assign flags = flags_q;

endmodule
`default_nettype wire

// >>> tpoc_top.sv
// top of the three-phase overcurrent trip block: curve evaluation and decision logic
`default_nettype none
`include "tpoc_map.svh"
module tpoc_top
	import tpoc_pkg::*;
#(
	parameter int TICK_CYCLES = `TPOC_TICK_CYCLES
)
(
	input  wire logic          ref_clk,
	input  wire logic          reset,
	input  wire logic          clk_en,
	input  wire logic [15:0]   phase1_current_mag,
	input  wire logic [15:0]   phase2_current_mag,
	input  wire logic [15:0]   phase3_current_mag,
	input  wire tpoc_setting_s settings,
	input  wire logic          function_block_in,
	output logic               phase1_start_flag,
	output logic               phase1_trip_flag,
	output logic               phase2_start_flag,
	output logic               phase2_trip_flag,
	output logic               phase3_start_flag,
	output logic               phase3_trip_flag,
	output logic               general_start_out,
	output logic               general_trip_out
);

	// ********************************************
	// curve helpers
	// ********************************************

	// ratio bucket of magnitude over threshold, 0 = 1.1 .. 7 = 20 and above
	function automatic logic [2:0] op_bucket(input logic [15:0] mag, input logic [11:0] thr);
		logic [31:0] m;
		logic [31:0] t;
		logic [2:0]  b;
		m = 32'(mag) * 32'd10;
		t = 32'(thr);
		b = 3'd0;
		if (m >= t * `TPOC_BP2) b = 3'd1;
		if (m >= t * `TPOC_BP3) b = 3'd2;
		if (m >= t * `TPOC_BP4) b = 3'd3;
		if (m >= t * `TPOC_BP5) b = 3'd4;
		if (m >= t * `TPOC_BP6) b = 3'd5;
		if (m >= t * `TPOC_BP7) b = 3'd6;
		if (m >= t * `TPOC_BP8) b = 3'd7;
		return b;
	endfunction

	// reset-factor bucket of magnitude over threshold below one
	function automatic logic [31:0] rst_factor(input logic [15:0] mag, input logic [11:0] thr);
		logic [31:0] m;
		logic [31:0] t;
		logic [31:0] f;
		m = 32'(mag) * 32'd100;
		t = 32'(thr);
		f = `TPOC_RFAC0;
		if (m >= t * `TPOC_RBP1) f = `TPOC_RFAC1;
		if (m >= t * `TPOC_RBP2) f = `TPOC_RFAC2;
		if (m >= t * `TPOC_RBP3) f = `TPOC_RFAC3;
		return f;
	endfunction

	// operate time in ms at unit multiplier: k/(r^alpha-1)+c at each breakpoint
	function automatic logic [31:0] curve_ms(input tpoc_curve_e c, input logic [2:0] b);
		logic [31:0] v [8];
		v = '{default: 32'd0};
		case (c)
			TPOC_IEC_INV:        v = '{73375, 17195, 10029, 6302, 4280, 3528, 2971, 2267};
			TPOC_IEC_VERY_INV:   v = '{135000, 27000, 13500, 6750, 3375, 2250, 1500, 711};
			TPOC_IEC_EXT_INV:    v = '{380952, 64000, 26667, 10000, 3333, 1667, 808, 201};
			TPOC_IEC_LONG_INV:   v = '{1200000, 240000, 120000, 60000, 30000, 20000, 13333, 6316};
			TPOC_ANSI_INV:       v = '{4526, 1075, 635, 406, 281, 235, 201, 158};
			TPOC_ANSI_MOD_INV:   v = '{27106, 6439, 3803, 2432, 1688, 1412, 1207, 948};
			TPOC_ANSI_VERY_INV:  v = '{93872, 16179, 7028, 2942, 1308, 900, 689, 540};
			TPOC_ANSI_EXT_INV:   v = '{134408, 22682, 9522, 3647, 1297, 709, 407, 192};
			TPOC_ANSI_LONG_INV:  v = '{45260, 10748, 6345, 4056, 2814, 2352, 2010, 1578};
			TPOC_ANSI_LVERY_INV: v = '{136664, 23552, 10229, 4281, 1902, 1307, 1000, 784};
			TPOC_ANSI_LEXT_INV:  v = '{305345, 51506, 21607, 8259, 2920, 1585, 897, 411};
			default:             v = '{default: 32'd0};
		endcase
		return v[b];
	endfunction

	// ANSI reset constant kr in ms, zero for other curves
	function automatic logic [31:0] reset_kr(input tpoc_curve_e c);
		case (c)
			TPOC_ANSI_INV:       return 32'd460;
			TPOC_ANSI_MOD_INV:   return 32'd4850;
			TPOC_ANSI_VERY_INV:  return 32'd21600;
			TPOC_ANSI_EXT_INV:   return 32'd29100;
			TPOC_ANSI_LONG_INV:  return 32'd4600;
			TPOC_ANSI_LVERY_INV: return 32'd13460;
			TPOC_ANSI_LEXT_INV:  return 32'd30000;
			default:             return 32'd0;
		endcase
	endfunction

	// ********************************************
	// evaluation tick
	// ********************************************
	logic [31:0] tick_cnt_q, tick_cnt_d;
	logic        ms_tick;

	// one tick per millisecond drives every phase timer
	always_comb begin
		ms_tick    = (tick_cnt_q == 32'(TICK_CYCLES - 1));
		tick_cnt_d = ms_tick ? 32'd0 : tick_cnt_q + 32'd1;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			tick_cnt_q <= 32'd0;
		end else if (clk_en) begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// ********************************************
	// function enable
	// ********************************************
	logic active;
	logic is_iec;
	logic is_definite;

	always_comb begin
		active      = (settings.curve != TPOC_OFF) && !function_block_in;
		is_definite = (settings.curve == TPOC_DEFINITE);
		is_iec      = (settings.curve >= TPOC_IEC_INV) && (settings.curve <= TPOC_IEC_LONG_INV);
	end

	// ********************************************
	// per-phase delay evaluation and timers
	// ********************************************
	logic [15:0] mag [3];
	tpoc_flags_s flags [3];

	assign mag[0] = phase1_current_mag;
	assign mag[1] = phase2_current_mag;
	assign mag[2] = phase3_current_mag;

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			logic [31:0] op_d, op_q;
			logic [31:0] rs_d, rs_q;
			logic        above_d, above_q;
			logic [31:0] inv_ms;
			logic [31:0] kr_fac;

			// curve result is registered, so phase timers see settled values a cycle later
			always_comb begin
				above_d = (mag[p] > 16'(settings.start_threshold));
				inv_ms  = curve_ms(settings.curve, op_bucket(mag[p], settings.start_threshold))
				          * 32'(settings.time_mult) / `TPOC_TMS_SCALE;
				kr_fac  = (reset_kr(settings.curve) * rst_factor(mag[p], settings.start_threshold))
				          >> `TPOC_RFAC_SHIFT;
				if (is_definite) begin
					op_d = 32'(settings.def_delay_ms);
				end else if (32'(settings.min_delay_ms) > inv_ms) begin
					op_d = 32'(settings.min_delay_ms);
				end else begin
					op_d = inv_ms;
				end
				if (is_iec) begin
					rs_d = 32'(settings.reset_delay_ms);
				end else begin
					rs_d = kr_fac * 32'(settings.time_mult) / `TPOC_TMS_SCALE;
				end
			end

			always_ff @(posedge ref_clk) begin
				if (reset) begin
					op_q    <= 32'd0;
					rs_q    <= 32'd0;
					above_q <= 1'b0;
				end else if (clk_en) begin
					op_q    <= op_d;
					rs_q    <= rs_d;
					above_q <= above_d;
				end
			end

			tpoc_phase u_phase (
				.ref_clk     (ref_clk),
				.reset       (reset),
				.clk_en      (clk_en),
				.ms_tick     (ms_tick),
				.clear       (!active),
				.above       (above_q),
				.immed_reset (is_definite),
				.op_delay    (op_q),
				.rst_delay   (rs_q),
				.flags       (flags[p])
			);
		end
	endgenerate

	// ********************************************
	// decision logic
	// ********************************************
	logic gen_start_q, gen_start_d;
	logic gen_trip_q, gen_trip_d;

	// combining the registered phase flags keeps general outputs aligned one cycle behind
	always_comb begin
		gen_start_d = active && (flags[0].start || flags[1].start || flags[2].start);
		gen_trip_d  = active && (flags[0].trip || flags[1].trip || flags[2].trip);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gen_start_q <= 1'b0;
			gen_trip_q  <= 1'b0;
		end else if (clk_en) begin
			gen_start_q <= gen_start_d;
			gen_trip_q  <= gen_trip_d;
		end
	end

	assign phase1_start_flag = flags[0].start;
	assign phase1_trip_flag  = flags[0].trip;
	assign phase2_start_flag = flags[1].start;
	assign phase2_trip_flag  = flags[1].trip;
	assign phase3_start_flag = flags[2].start;
	assign phase3_trip_flag  = flags[2].trip;
	assign general_start_out = gen_start_q;
	assign general_trip_out  = gen_trip_q;

endmodule
`default_nettype wire

// >>> tpoc_asserts.sv
// assertion checker of the three-phase overcurrent trip block
`default_nettype none
module tpoc_asserts
	import tpoc_pkg::*;
#(
	parameter int TICK_CYCLES = 10
)
(
	input wire logic          ref_clk,
	input wire logic          reset,
	input wire logic          clk_en,
	input wire logic [15:0]   phase1_current_mag,
	input wire logic [15:0]   phase2_current_mag,
	input wire logic [15:0]   phase3_current_mag,
	input wire tpoc_setting_s settings,
	input wire logic          function_block_in,
	input wire logic          phase1_start_flag,
	input wire logic          phase1_trip_flag,
	input wire logic          phase2_start_flag,
	input wire logic          phase2_trip_flag,
	input wire logic          phase3_start_flag,
	input wire logic          phase3_trip_flag,
	input wire logic          general_start_out,
	input wire logic          general_trip_out
);
	// ****************
	// helper logic
	// ****************
	logic [31:0] cyc_q;
	logic [31:0] cyc_d;
	logic        any_s;
	logic        any_t;
	logic        dt;
	logic        run;

	// cycles spent started in phase one; a long count is cheaper here than a repetition
	always_comb begin
		cyc_d = cyc_q;
		if (!phase1_start_flag) cyc_d = '0;
		else if (clk_en) cyc_d = cyc_q + 32'h1;
	end
	always_ff @(posedge ref_clk) begin
		if (reset) cyc_q <= '0;
		else cyc_q <= cyc_d;
	end

	// combined flags and qualifiers
	assign any_s = phase1_start_flag | phase2_start_flag | phase3_start_flag;
	assign any_t = phase1_trip_flag | phase2_trip_flag | phase3_trip_flag;
	assign dt = settings.curve == TPOC_DEFINITE;
	assign run = clk_en && !function_block_in && settings.curve != TPOC_OFF;

	// ****************
	// properties
	// ****************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_above1;
		run && phase1_current_mag > settings.start_threshold;
	endsequence
	sequence s_below1;
		clk_en && phase1_current_mag <= settings.start_threshold;
	endsequence

	property p_gs_on;  run && any_s |=> general_start_out; endproperty
	property p_gs_off; clk_en && !any_s |=> !general_start_out; endproperty
	property p_gt_on;  run && any_t |=> general_trip_out; endproperty
	property p_gt_off; clk_en && !any_t |=> !general_trip_out; endproperty
	property p_blk;
		clk_en && function_block_in |=> !any_s && !any_t && !general_start_out && !general_trip_out;
	endproperty
	property p_off;    clk_en && settings.curve == TPOC_OFF |=> !any_s && !any_t; endproperty
	property p_st_rise; s_above1 [*2] |=> phase1_start_flag; endproperty
	property p_st_drop; s_below1 [*2] |=> !phase1_start_flag; endproperty
	property p_early;
		$rose(phase1_trip_flag) && dt |-> cyc_q >= (settings.def_delay_ms - 1) * TICK_CYCLES;
	endproperty
	property p_late;
		dt && phase1_start_flag && !phase1_trip_flag |-> cyc_q <= (settings.def_delay_ms + 1) * TICK_CYCLES;
	endproperty

	a_gs_on: assert property (p_gs_on) else $error("general start missing");
	a_gs_off: assert property (p_gs_off) else $error("general start without phase start");
	a_gt_on: assert property (p_gt_on) else $error("general trip missing");
	a_gt_off: assert property (p_gt_off) else $error("general trip without phase trip");
	a_blk: assert property (p_blk) else $error("outputs not cleared by block");
	a_off: assert property (p_off) else $error("outputs not cleared when off");
	a_st_rise: assert property (p_st_rise) else $error("phase one start missing");
	a_st_drop: assert property (p_st_drop) else $error("phase one start stuck");
	a_early: assert property (p_early) else $error("definite trip too early");
	a_late: assert property (p_late) else $error("definite trip too late");
endmodule
`default_nettype wire

// >>> tpoc_meas_model.sv
// magnitude source standing in for the phase current measurement
`default_nettype none
module tpoc_meas_model
(
	input  wire logic        ref_clk,
	input  wire logic [47:0] target,
	output var logic  [15:0] mag1,
	output var logic  [15:0] mag2,
	output var logic  [15:0] mag3
);
	timeunit 1ns;
	timeprecision 1ps;
	// one cycle of measurement latency; each phase carries its own magnitude
	initial {mag3, mag2, mag1} = '0;
	always @(posedge ref_clk) begin
		{mag3, mag2, mag1} <= target;
	end
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking testbench of the three-phase overcurrent trip block
`default_nettype none
module tb
	import tpoc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	logic          ref_clk = 1'b0;
	logic          reset = 1'b1;
	logic          clk_en = 1'b1;
	logic          function_block_in = 1'b0;
	logic [47:0]   tgt = '0;
	logic [15:0]   phase1_current_mag, phase2_current_mag, phase3_current_mag;
	tpoc_setting_s settings = '{TPOC_OFF, 12'hc8, 11'h00a, 16'h28, 16'h28, 16'h3c};
	logic          phase1_start_flag, phase1_trip_flag, phase2_start_flag, phase2_trip_flag;
	logic          phase3_start_flag, phase3_trip_flag, general_start_out, general_trip_out;
	int            num_errors = 0;
	int            comparisons = 0;

	// ****************
	// clock, design and source
	// ****************
	initial forever #2.5 ref_clk = ~ref_clk;
	tpoc_meas_model u_src (.ref_clk, .target(tgt), .mag1(phase1_current_mag), .mag2(phase2_current_mag),
		.mag3(phase3_current_mag));
	tpoc_top #(.TICK_CYCLES(TK)) uut (.ref_clk, .reset, .clk_en, .phase1_current_mag, .phase2_current_mag,
		.phase3_current_mag, .settings, .function_block_in, .phase1_start_flag, .phase1_trip_flag,
		.phase2_start_flag, .phase2_trip_flag, .phase3_start_flag, .phase3_trip_flag, .general_start_out,
		.general_trip_out);

	// ****************
	// helpers
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// curve and magnitudes change together just after an edge
	task automatic go(input tpoc_curve_e c, input logic [15:0] a, input logic [15:0] b, input logic [15:0] d);
		@(posedge ref_clk);
		settings.curve <= c;
		tgt <= {d, b, a};
	endtask
	// off also returns every timer to idle, so each test starts clean
	task automatic quiet();
		go(TPOC_OFF, 16'h0, 16'h0, 16'h0);
		function_block_in <= 1'b0;
		settings.start_threshold <= 12'hc8;
		repeat (6) @(negedge ref_clk);
	endtask
	// bounded wait on a general output, sampled mid-cycle where it is settled
	task automatic wt(input bit tr, input int lim, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while ((tr ? general_trip_out : general_start_out) !== 1'b1 && n < lim);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************
	// scenarios
	// ****************
	task automatic t_idle();
		chk({phase1_start_flag, phase1_trip_flag, phase2_start_flag, phase2_trip_flag, phase3_start_flag,
			phase3_trip_flag, general_start_out, general_trip_out}, 0);
		done("idle");
	endtask
	task automatic t_def();
		int n;
		go(TPOC_DEFINITE, 16'h0, 16'h190, 16'h0);
		wt(0, 8, n);
		chk(n <= 5, 1);
		chk({phase1_start_flag, phase2_start_flag, phase3_start_flag}, 3'b010);
		wt(1, 500, n);
		chk(n >= 39 * TK && n <= 42 * TK, 1);
		chk({phase1_trip_flag, phase2_trip_flag, phase3_trip_flag}, 3'b010);
		go(TPOC_DEFINITE, 16'h0, 16'h0, 16'h0);
		repeat (5) @(negedge ref_clk);
		chk({general_start_out, general_trip_out}, 0);
		quiet();
		done("definite");
	endtask
	task automatic t_thr();
		int n;
		go(TPOC_DEFINITE, 16'hbb8, 16'h0, 16'h0);
		settings.start_threshold <= 12'hbb8;
		repeat (20) @(negedge ref_clk);
		chk(phase1_start_flag, 0);
		go(TPOC_DEFINITE, 16'hbb9, 16'h0, 16'h0);
		wt(0, 8, n);
		chk(phase1_start_flag, 1);
		quiet();
		done("threshold");
	endtask
	task automatic t_blk();
		int n;
		go(TPOC_DEFINITE, 16'h1f4, 16'h1f4, 16'h1f4);
		wt(1, 500, n);
		chk({phase1_trip_flag, phase2_trip_flag, phase3_trip_flag}, 3'b111);
		@(posedge ref_clk);
		function_block_in <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({phase1_start_flag, phase1_trip_flag, phase2_start_flag, phase2_trip_flag, phase3_start_flag,
			phase3_trip_flag, general_start_out, general_trip_out}, 0);
		@(posedge ref_clk);
		function_block_in <= 1'b0;
		wt(0, 8, n);
		chk({general_start_out, general_trip_out, phase1_trip_flag}, 3'b100);
		quiet();
		done("block");
	endtask
	task automatic t_off();
		go(TPOC_OFF, 16'h3e8, 16'h3e8, 16'h3e8);
		repeat (30) @(negedge ref_clk);
		chk({phase1_start_flag, phase2_start_flag, general_start_out, general_trip_out}, 0);
		quiet();
		done("off");
	endtask
	// every inverse curve at thirty times threshold, multiplier 0.10, minimum 40 ms
	task automatic t_crv();
		int n;
		int ex[11] = '{227, 71, 40, 632, 40, 95, 54, 40, 158, 78, 41};
		for (int i = 0; i < 11; i++) begin
			go(tpoc_curve_e'(i + 2), 16'h0, 16'h0, 16'h1770);
			wt(1, 700 * TK, n);
			chk(n / TK >= ex[i] - ex[i] / 25 - 3 && n / TK <= ex[i] + ex[i] / 25 + 3, 1);
			quiet();
		end
		done("curves");
	endtask
	// a short dip keeps elapsed time, a dip past the reset delay clears it
	task automatic t_rst();
		int n;
		go(TPOC_IEC_VERY_INV, 16'h1770, 16'h0, 16'h0);
		repeat (300) @(negedge ref_clk);
		go(TPOC_IEC_VERY_INV, 16'h0, 16'h0, 16'h0);
		repeat (200) @(negedge ref_clk);
		go(TPOC_IEC_VERY_INV, 16'h1770, 16'h0, 16'h0);
		wt(1, 900, n);
		chk(n <= 48 * TK, 1);
		go(TPOC_IEC_VERY_INV, 16'h0, 16'h0, 16'h0);
		repeat (1000) @(negedge ref_clk);
		go(TPOC_IEC_VERY_INV, 16'h1770, 16'h0, 16'h0);
		wt(1, 900, n);
		chk(n >= 66 * TK, 1);
		quiet();
		done("iec reset");
	endtask
	// ANSI inverse at 0.10 with no current resets after 46 ms, so 20 ms keeps and 53 ms clears
	task automatic t_ansi();
		int n;
		go(TPOC_ANSI_INV, 16'h1770, 16'h0, 16'h0);
		repeat (250) @(negedge ref_clk);
		go(TPOC_ANSI_INV, 16'h0, 16'h0, 16'h0);
		repeat (200) @(negedge ref_clk);
		go(TPOC_ANSI_INV, 16'h1770, 16'h0, 16'h0);
		wt(1, 600, n);
		chk(n <= 25 * TK, 1);
		go(TPOC_ANSI_INV, 16'h0, 16'h0, 16'h0);
		repeat (530) @(negedge ref_clk);
		go(TPOC_ANSI_INV, 16'h1770, 16'h0, 16'h0);
		wt(1, 600, n);
		chk(n >= 35 * TK, 1);
		quiet();
		done("ansi reset");
	endtask
	// a low clock enable freezes the running delay, so the trip only comes after the freeze
	task automatic t_cke();
		int n;
		go(TPOC_DEFINITE, 16'h190, 16'h0, 16'h0);
		wt(0, 8, n);
		@(posedge ref_clk);
		clk_en <= 1'b0;
		repeat (500) @(negedge ref_clk);
		chk({phase1_start_flag, phase1_trip_flag, general_start_out, general_trip_out}, 4'b1010);
		@(posedge ref_clk);
		clk_en <= 1'b1;
		wt(1, 500, n);
		chk(n >= 38 * TK && n <= 42 * TK, 1);
		quiet();
		done("clock enable");
	endtask

	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		t_idle();
		t_def();
		t_thr();
		t_blk();
		t_off();
		t_crv();
		t_rst();
		t_ansi();
		t_cke();
		final_report();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		num_errors++;
		final_report();
	end
endmodule

bind tpoc_top tpoc_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk, .reset, .clk_en, .phase1_current_mag,
	.phase2_current_mag, .phase3_current_mag, .settings, .function_block_in, .phase1_start_flag,
	.phase1_trip_flag, .phase2_start_flag, .phase2_trip_flag, .phase3_start_flag, .phase3_trip_flag,
	.general_start_out, .general_trip_out);
`default_nettype wire
